// [logic/rtcc_cfg.svh]
// constants for the counter capture and strobe sampling block
`ifndef RTCC_CFG_SVH
`define RTCC_CFG_SVH
`define RTCC_CNT_W      32
`define RTCC_CHANNELS   4
`define RTCC_INPUTS     3
`define RTCC_CNT_RST    32'h0000_0000
`define RTCC_SAMPLE_DLY 8'h02
`endif

// [logic/rtcc_pkg.sv]
// types for the counter capture and strobe sampling block
`include "rtcc_cfg.svh"
package rtcc_pkg;
    typedef logic [`RTCC_INPUTS-1:0] rtcc_in_t;
    typedef struct packed {
        logic                  valid;
        logic [`RTCC_CNT_W-1:0] count;
    } rtcc_cap_t;
    typedef struct packed {
        logic [7:0]            period;
        logic [7:0]            width;
    } rtcc_strobe_cfg_t;
endpackage

// [logic/rtcc_top.sv]
// counter capture, strobe pulses and timed sampling of sensor inputs
`timescale 1ns/1ps
`include "rtcc_cfg.svh"
module rtcc_top #(
    parameter int CH = `RTCC_CHANNELS,
    parameter int NI = `RTCC_INPUTS,
    parameter int CW = `RTCC_CNT_W
) (
    input  wire logic                              clk,
    input  wire logic                              rst_n,
    input  wire logic                              cap_pin,
    input  wire logic                              cap_rise_en,
    input  wire logic                              cap_fall_en,
    input  wire logic                              cap_ack,
    input  wire logic [CH-1:0][NI-1:0]             ret_pin,
    input  wire rtcc_pkg::rtcc_strobe_cfg_t [CH-1:0] strobe_cfg,
    input  wire logic [CH-1:0][CW-1:0]             strobe_target,
    input  wire logic [CH-1:0]                     act_irq_en,
    input  wire logic [CH-1:0]                     seq_en,
    input  wire logic [CH-1:0][NI-1:0]             seq_first,
    input  wire logic [CH-1:0][NI-1:0]             seq_second,
    output logic [CW-1:0]                          count_reg,
    output rtcc_pkg::rtcc_cap_t                    cap_reg,
    output logic [CH-1:0]                          pulse_reg,
    output logic [CH-1:0][NI-1:0]                  sample_reg,
    output logic                                   irq_reg,
    output logic                                   wake_reg
);
    import rtcc_pkg::*;

    // ------------------------------------------------------------
    // running counter, one tick per clock (counter clock)
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= `RTCC_CNT_RST;
        end else begin
            count_reg <= count_reg + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // capture input
    // ------------------------------------------------------------
    logic cap_s1_reg, cap_s2_reg, cap_s3_reg;
    logic cap_edge;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cap_s1_reg <= 1'b0;
            cap_s2_reg <= 1'b0;
            cap_s3_reg <= 1'b0;
        end else begin
            cap_s1_reg <= cap_pin;
            cap_s2_reg <= cap_s1_reg;
            cap_s3_reg <= cap_s2_reg;
        end
    end
    // edges only; pin assumed held long enough to pass sync
    assign cap_edge = (cap_rise_en && cap_s2_reg && !cap_s3_reg) ||
                      (cap_fall_en && !cap_s2_reg && cap_s3_reg);

    // count is taken one cycle after the edge reached the sync output,
    // so software subtracts a fixed latency of two cycles;
    // an edge in the cycle of the acknowledge is kept, set wins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cap_reg <= '0;
        end else if (cap_edge && (!cap_reg.valid || cap_ack)) begin
            cap_reg.valid <= 1'b1;
            cap_reg.count <= count_reg;
        end else if (cap_ack && !cap_edge) begin
            cap_reg.valid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // strobe channels and sampling
    // ------------------------------------------------------------
    logic [CH-1:0] act_hit;
    logic [CH-1:0] seq_hit;
    genvar c;
    generate
        for (c = 0; c < CH; c++) begin : g_ch
            logic [7:0]    ph_reg;
            logic          armed_reg;
            logic [7:0]    dly_reg;
            logic [NI-1:0] r1_reg, r2_reg;
            logic          stage_reg;
            logic          fire;
            assign fire = armed_reg ? (ph_reg == strobe_cfg[c].period)
                        : (count_reg == strobe_target[c]);
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    ph_reg    <= 8'h00;
                    armed_reg <= 1'b0;
                    pulse_reg[c] <= 1'b0;
                end else begin
                    if (fire) begin
                        armed_reg <= 1'b1;
                        ph_reg    <= 8'h00;
                    end else if (armed_reg) begin
                        ph_reg <= ph_reg + 8'h01;
                    end
                    // duty set by width, rate by period
                    pulse_reg[c] <= fire || (armed_reg &&
                        ph_reg < strobe_cfg[c].width);
                end
            end
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    r1_reg <= '0;
                    r2_reg <= '0;
                end else begin
                    r1_reg <= ret_pin[c];
                    r2_reg <= r1_reg;
                end
            end
            // sample a fixed delay after the pulse starts, giving the
            // sensor time to answer
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    dly_reg <= 8'h00;
                    sample_reg[c] <= '0;
                    stage_reg <= 1'b0;
                end else begin
                    if (fire) begin
                        dly_reg <= `RTCC_SAMPLE_DLY;
                    end else if (dly_reg != 8'h00) begin
                        dly_reg <= dly_reg - 8'h01;
                    end
                    if (dly_reg == 8'h01) begin
                        sample_reg[c] <= r2_reg;
                        if (r2_reg == seq_first[c]) begin
                            stage_reg <= 1'b1;
                        end else if (stage_reg) begin
                            stage_reg <= 1'b0;
                        end
                    end
                end
            end
            assign act_hit[c] = act_irq_en[c] && (dly_reg == 8'h01) &&
                (r2_reg != sample_reg[c]);
            assign seq_hit[c] = seq_en[c] && (dly_reg == 8'h01) &&
                stage_reg && (r2_reg == seq_second[c]);
        end
    endgenerate

    // ------------------------------------------------------------
    // wake and interrupt; set wins over acknowledge
    // ------------------------------------------------------------
    logic cap_new;
    assign cap_new = cap_edge && (!cap_reg.valid || cap_ack);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_reg  <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            if (cap_new || (|act_hit) || (|seq_hit)) begin
                irq_reg <= 1'b1;
            end else if (cap_ack) begin
                irq_reg <= 1'b0;
            end
            if (cap_new || (|seq_hit)) begin
                wake_reg <= 1'b1;
            end else if (cap_ack) begin
                wake_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_cap_takes_count: assert property (@(posedge clk) disable iff (!rst_n)
        cap_new |=> cap_reg.valid && cap_reg.count == $past(count_reg))
        else $error("capture did not latch count");
    a_cap_irq_wake: assert property (@(posedge clk) disable iff (!rst_n)
        cap_new |=> irq_reg && wake_reg)
        else $error("capture raised no wake");
    a_cap_exact_cycle: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(cap_s2_reg) && cap_rise_en && !cap_reg.valid && !cap_ack
        |=> ##1 cap_reg.count == count_reg - 32'h0000_0002)
        else $error("capture cycle wrong");
    a_cap_held: assert property (@(posedge clk) disable iff (!rst_n)
        cap_reg.valid && !cap_ack |=> cap_reg.valid &&
        $stable(cap_reg.count))
        else $error("capture changed before read");
    a_sync_delay: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |-> ##2 cap_s2_reg == $past(cap_pin, 2))
        else $error("sync depth wrong");
    a_ret_delay: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |-> ##2 g_ch[0].r2_reg == $past(ret_pin[0], 2))
        else $error("return sync wrong");
    a_sample_time: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(sample_reg[0]) |-> $past(g_ch[0].dly_reg) == 8'h01)
        else $error("sample off strobe timing");
    a_act_irq: assert property (@(posedge clk) disable iff (!rst_n)
        act_hit[0] |=> irq_reg)
        else $error("activity raised no irq");
    a_seq_wake: assert property (@(posedge clk) disable iff (!rst_n)
        !cap_new && !(|seq_hit) && !wake_reg |=> !wake_reg)
        else $error("wake without cause");
    a_target_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        !g_ch[0].armed_reg && count_reg == strobe_target[0]
        |=> pulse_reg[0])
        else $error("strobe missed target");
    a_pulse_duty: assert property (@(posedge clk) disable iff (!rst_n)
        g_ch[1].armed_reg && !g_ch[1].fire &&
        g_ch[1].ph_reg >= strobe_cfg[1].width |=> !pulse_reg[1])
        else $error("pulse wider than duty");
endmodule // rtcc_top

// [verif/rtcc_sensor.sv]
// behavioural model of the external sensor on the capture and return pins
`timescale 1ns/1ps
module rtcc_sensor (
    input  wire logic       clk,
    output logic            cap_pin,
    output logic [3:0][2:0] ret_pin
);
    initial begin
        cap_pin = 1'b0;
        ret_pin = '0;
    end
    // ------------------------------------------------------------
    // event signalling
    // ------------------------------------------------------------
    // the level is held, never pulsed, so the device may sample it late
    task automatic edge_event(input logic lvl);
        @(negedge clk);
        cap_pin = lvl;
    endtask
    task automatic show(input int ch, input logic [2:0] v);
        @(negedge clk);
        ret_pin[ch] = v;
    endtask
endmodule // rtcc_sensor

// [verif/rtcc_top_tb.sv]
// self-checking bench for capture, strobe pulses and timed sampling
`timescale 1ns/1ps
module rtcc_top_tb;
    import rtcc_pkg::*;
    logic                        clk = 1'b0;
    logic                        rst_n = 1'b0;
    logic                        cap_pin;
    logic                        cap_rise_en = 1'b0;
    logic                        cap_fall_en = 1'b0;
    logic                        cap_ack = 1'b0;
    logic [3:0][2:0]             ret_pin;
    rtcc_strobe_cfg_t [3:0]      strobe_cfg;
    logic [3:0][31:0]            strobe_target;
    logic [3:0]                  act_irq_en = 4'hf;
    logic [3:0]                  seq_en = 4'h0;
    logic [3:0][2:0]             seq_first = '0;
    logic [3:0][2:0]             seq_second = '0;
    logic [31:0]                 count_reg;
    rtcc_cap_t                   cap_reg;
    logic [3:0]                  pulse_reg;
    logic [3:0][2:0]             sample_reg;
    logic                        irq_reg;
    logic                        wake_reg;
    logic [31:0]                 cyc = '0;
    logic [31:0]                 exp;
    int                          n_fail = 0;
    int                          n_compared = 0;
    always #25 clk = ~clk;
    // own count of edges since release, the reference for all timing
    always @(posedge clk) cyc <= rst_n ? cyc + 32'h0000_0001 : '0;
    rtcc_top rtcc_top_i (.clk, .rst_n, .cap_pin, .cap_rise_en, .cap_fall_en,
        .cap_ack, .ret_pin, .strobe_cfg, .strobe_target, .act_irq_en,
        .seq_en, .seq_first, .seq_second, .count_reg, .cap_reg, .pulse_reg,
        .sample_reg, .irq_reg, .wake_reg);
    rtcc_sensor rtcc_sensor_i (.clk, .cap_pin, .ret_pin);
    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                want);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic acknowledge();
        @(negedge clk);
        cap_ack = 1'b1;
        @(negedge clk);
        cap_ack = 1'b0;
    endtask
    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_capture();
        cap_rise_en = 1'b1;
        cap_fall_en = 1'b1;
        rtcc_sensor_i.edge_event(1'b1);
        // count of the cycle in which the pin moved, plus fixed latency
        exp = cyc + 32'h0000_0002;
        tick(2);
        check(count_reg, cyc);
        check(32'(cap_reg.valid), 32'h0000_0000);
        tick(1);
        check(32'(cap_reg.valid), 32'h0000_0001);
        check(cap_reg.count, exp);
        check({30'h0, irq_reg, wake_reg}, 32'h0000_0003);
        // a second edge while the first is unread must be dropped
        rtcc_sensor_i.edge_event(1'b0);
        tick(6);
        check(cap_reg.count, exp);
        acknowledge();
        tick(1);
        check({cap_reg.valid, irq_reg, wake_reg}, 32'h0000_0000);
        @(negedge clk);
        cap_rise_en = 1'b0;
        rtcc_sensor_i.edge_event(1'b1);
        tick(6);
        check(32'(cap_reg.valid), 32'h0000_0000);
    endtask
    task automatic t_strobe();
        for (int c = 0; c < 4; c++) begin
            do tick(1); while (cyc != strobe_target[c]);
            for (int k = 1; k <= 10; k++) begin
                tick(1);
                check(32'(pulse_reg[c]), 32'(k <= c + 2));
                if (k == 2)
                    check(32'(sample_reg[c]), 32'h0000_0000);
                if (k == 3)
                    check(32'(sample_reg[c]), 32'(c + 1));
                if (k == 3)
                    check(32'(irq_reg), 32'h0000_0001);
            end
            acknowledge();
        end
    endtask
    task automatic t_sequence();
        act_irq_en = 4'h0;
        seq_en = 4'h2;
        seq_first[1] = 3'h5;
        seq_second[1] = 3'h2;
        do tick(1); while ((cyc - strobe_target[1]) % 10 != 3);
        rtcc_sensor_i.show(1, 3'h5);
        tick(10);
        check(32'(wake_reg), 32'h0000_0000);
        rtcc_sensor_i.show(1, 3'h2);
        tick(10);
        check(32'(wake_reg), 32'h0000_0001);
    endtask
    initial begin
        for (int c = 0; c < 4; c++) begin
            strobe_cfg[c] = '{period: 8'h09, width: 8'(c + 1)};
            strobe_target[c] = 32'h0000_0100 + 32'(32 * c);
        end
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        tick(0);
        check({pulse_reg, cap_reg.valid, irq_reg, wake_reg}, 32'h0);
        for (int c = 0; c < 4; c++)
            rtcc_sensor_i.show(c, 3'(c + 1));
        t_capture();
        t_strobe();
        t_sequence();
        end_of_test();
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        end_of_test();
    end
endmodule // rtcc_top_tb
